// ### inc/dgc_if.sv
`timescale 1ns/10ps
interface dgc_if;
	logic [1:0] iface_sel;
	logic       power_mode_select;
	logic       chan_a_power_up;
	logic       chan_b_power_up;
	logic       chan_a_hold;
	logic       chan_b_hold;
	logic [5:0] chan_a_gain_inputs;
	logic [5:0] chan_b_gain_inputs;
	logic       sdio_dev_out;
	logic       sdio_dev_oe;
	logic       sdio_host_out;
	logic       sdio_host_oe;
	wire        sdio_line = sdio_dev_oe ? sdio_dev_out : (sdio_host_oe ? sdio_host_out : 1'b1);
	modport device (input iface_sel, power_mode_select, chan_a_power_up, chan_b_power_up, chan_a_hold, chan_b_hold,
		chan_a_gain_inputs, chan_b_gain_inputs, sdio_line, output sdio_dev_out, sdio_dev_oe);
	modport host (output iface_sel, power_mode_select, chan_a_power_up, chan_b_power_up, chan_a_hold, chan_b_hold,
		chan_a_gain_inputs, chan_b_gain_inputs, sdio_host_out, sdio_host_oe, input sdio_line);
endinterface : dgc_if

// ### inc/dgc_pkg.sv
package dgc_pkg;
	localparam int GAIN_W = 6;
	localparam int WORD_W = 16;
	// serial word layout, msb first on the line
	localparam int RW_POS = 8;
	localparam int QSTEP_HI_POS = 7;
	localparam int QSTEP_LO_POS = 6;
	localparam int GAIN_LSB_POS = 0;
	localparam logic [5:0] GAIN_RESET = 6'h3F;
	localparam logic [5:0] GAIN_MIN_CODE = 6'h23;
	localparam logic [5:0] AMP_SPAN = 6'h0C;
	localparam logic [4:0] ATTEN_MAX = 5'h17;
	localparam logic [4:0] AMP_MAX_DB = 5'h1A;
	localparam logic [1:0] IFACE_PARALLEL = 2'h0;
	localparam logic [1:0] IFACE_SERIAL = 2'h1;
	localparam int SCLK_HALF_NS = 100;
	localparam int CLK_NS = 25;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {DGC_IDLE = 2'b00, DGC_LOW = 2'b01, DGC_HIGH = 2'b11, DGC_DONE = 2'b10} dgc_host_e;
endpackage : dgc_pkg

// ### rtl/dgc_device.sv
// Functional notes
// R1 - mode pins pick parallel, serial or up/down
// R2 - each channel keeps own 6-bit gain code
// R3 - code 0 is +26 dB, clamps -9 dB
// R4 - first 12 dB by amplifier, then attenuator
// R5 - hold low follows inputs, high freezes
// R6 - 16-bit word: gain, step, read flag
// R7 - host shifts 16 bits msb first
// R8 - both selects low writes both channels
// R9 - host reads one channel at a time
// R10 - quick attenuation steps 2/4/8/16 dB
// R11 - count pulse raises or lowers gain
// R12 - direction change within pulse resets to minimum
// R13 - count step 1/2/4/8 dB from step pins
// R14 - counter saturates, never wraps
// R15 - shared pins meaning follows mode
// R16 - power-up pin enables each channel
// R17 - power mode low is high performance
// R18 - register addressed only while select low
// R19 - read follows read flag, data on rise
// R20 - quick attenuation relative, clamped, released
// R21 - gain kept across power-down
`timescale 1ns/10ps
module dgc_device (
	input  wire logic       CLK_IN,
	input  wire logic       RST_N_IN,
	dgc_if.device           link,
	output logic [5:0]      GAIN_A_OUT,
	output logic [5:0]      GAIN_B_OUT,
	output logic [4:0]      ATTEN_A_OUT,
	output logic [4:0]      ATTEN_B_OUT,
	output logic [4:0]      AMP_A_OUT,
	output logic [4:0]      AMP_B_OUT,
	output logic [1:0]      ENABLE_OUT,
	output logic            LOW_POWER_OUT,
	output logic [15:0]     WORD_A_OUT,
	output logic [15:0]     WORD_B_OUT
);
	// every pin is asynchronous to CLK_IN: two flops first
	localparam int NPIN = 20;
	logic [NPIN-1:0] pin_raw, sync1, sync2;
	assign pin_raw = {link.iface_sel, link.power_mode_select, link.chan_a_power_up, link.chan_b_power_up,
		link.chan_a_hold, link.chan_b_hold, link.chan_a_gain_inputs, link.chan_b_gain_inputs, link.sdio_line};
	always_ff @(posedge CLK_IN) begin
		sync1 <= RST_N_IN ? pin_raw : '0;
		sync2 <= RST_N_IN ? sync1 : '0;
	end
	// slices follow the pin_raw order: mode on top, data line at bit 0
	wire [1:0] mode       = sync2[19:18];
	wire       pm         = sync2[17];
	wire [1:0] pwr        = sync2[16:15];
	wire [1:0] hold       = {sync2[13], sync2[14]};
	wire [5:0] a_in       = sync2[12:7];
	wire [5:0] b_in       = sync2[6:1];
	wire       sdio_in    = sync2[0];
	wire       is_par     = (mode == dgc_pkg::IFACE_PARALLEL); // R1
	wire       is_ser     = (mode == dgc_pkg::IFACE_SERIAL); // R1
	wire       is_cnt     = mode[1]; // R1
	// R15: pin meanings by mode
	wire [1:0] sel_n      = {b_in[3], a_in[3]}; // R15
	wire       sclk       = b_in[4];
	wire [1:0] quick      = {b_in[2], a_in[2]};
	wire [1:0] cstep      = {b_in[3], b_in[2]};
	wire [1:0] cpulse     = {b_in[1], a_in[1]};
	wire [1:0] cdir       = {b_in[0], a_in[0]};
	logic       sclk_d;
	logic [1:0] pulse_d;
	wire        sclk_rise = sclk & ~sclk_d;
	wire [1:0]  any_sel   = ~sel_n;
	logic [15:0] shreg, word_a, word_b, rd_sh;
	logic [4:0]  bitcnt;
	logic [1:0]  rd_arm, rd_act;
	logic        sel_d;
	logic [1:0]  any_sel_q;
	wire         in_frame = is_ser & (any_sel != 2'b00); // R18
	wire         frame_end = sel_d & ~in_frame;
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			sclk_d <= 1'b0;
			sel_d <= 1'b0;
			pulse_d <= '0;
		end else begin
			sclk_d <= sclk;
			sel_d <= in_frame;
			pulse_d <= cpulse;
		end
	end
	// serial shifter
	wire [15:0] next_shreg = {shreg[14:0], sdio_in}; // R7
	wire        reading = |(rd_act & any_sel);
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			shreg <= '0;
			bitcnt <= '0;
			word_a <= {10'h000, dgc_pkg::GAIN_RESET};
			word_b <= {10'h000, dgc_pkg::GAIN_RESET};
			rd_arm <= '0;
			rd_act <= '0;
			rd_sh <= '0;
		end else begin
			if (!in_frame) begin
				bitcnt <= '0;
			end else if (sclk_rise && !reading) begin
				shreg <= next_shreg;
				bitcnt <= bitcnt + 5'h01;
			end
			if (in_frame && !sel_d) begin
				rd_act <= rd_arm & any_sel; // R19
				rd_sh <= any_sel[0] ? word_a : word_b; // R9
			end else if (in_frame && sclk_rise && reading && sel_d) begin
				rd_sh <= {rd_sh[14:0], 1'b0}; // R19
			end
			if (frame_end) begin
				rd_act <= '0;
				if (!reading && bitcnt == 5'h10) begin
					// R8: both selects latch the same word
					if (any_sel_q[0]) word_a <= shreg;
					if (any_sel_q[1]) word_b <= shreg;
					rd_arm <= {any_sel_q[1] & shreg[dgc_pkg::RW_POS], any_sel_q[0] & shreg[dgc_pkg::RW_POS]};
				end else begin
					rd_arm <= '0;
				end
			end
		end
	end
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) any_sel_q <= '0;
		else if (in_frame) any_sel_q <= any_sel;
	end
	// straight from the shifter: one more flop would push the change past sclk fall
	assign link.sdio_dev_out = rd_sh[15]; // R19
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			link.sdio_dev_oe <= 1'b0;
		end else begin
			link.sdio_dev_oe <= reading & in_frame & sel_d; // R19
		end
	end
	// per-channel gain state
	logic [5:0] code [2];
	wire  [5:0] par_in [2];
	wire  [1:0] sword_step [2];
	wire  [5:0] sword_gain [2];
	assign par_in[0] = a_in;
	assign par_in[1] = b_in;
	assign sword_gain[0] = word_a[5:0];
	assign sword_gain[1] = word_b[5:0];
	assign sword_step[0] = word_a[dgc_pkg::QSTEP_HI_POS:dgc_pkg::QSTEP_LO_POS];
	assign sword_step[1] = word_b[dgc_pkg::QSTEP_HI_POS:dgc_pkg::QSTEP_LO_POS];
	wire [5:0] cnt_step = 6'h01 << cstep; // R13
	logic [5:0] eff [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			wire       rise = cpulse[g] & ~pulse_d[g];
			wire       fall = ~cpulse[g] & pulse_d[g];
			wire [6:0] up   = {1'b0, code[g]} - {1'b0, cnt_step};
			wire [6:0] dn   = {1'b0, code[g]} + {1'b0, cnt_step};
			wire [5:0] next_up = up[6] ? 6'h00 : up[5:0]; // R14
			wire [5:0] next_dn = dn[6] ? dgc_pkg::GAIN_RESET : dn[5:0]; // R14
			wire [5:0] qstep = 6'h02 << sword_step[g]; // R10
			wire [6:0] qsum  = {1'b0, sword_gain[g]} + {1'b0, qstep};
			logic      dir_rise;
			always_ff @(posedge CLK_IN) begin
				if (!RST_N_IN) begin
					code[g] <= dgc_pkg::GAIN_RESET;
					dir_rise <= 1'b0;
				end else if (is_par) begin
					if (!hold[g]) code[g] <= par_in[g]; // R5
				end else if (is_cnt) begin
					if (rise) dir_rise <= cdir[g];
					if (fall) begin
						if (dir_rise != cdir[g]) code[g] <= dgc_pkg::GAIN_RESET; // R12
						else if (!cdir[g]) code[g] <= next_up; // R11
						else code[g] <= next_dn; // R11
					end
				end else begin
					code[g] <= sword_gain[g];
				end
			end
			// R20: applied above programmed gain, clamped, released when pin low
			assign eff[g] = (is_ser && quick[g]) ? (qsum[6] ? dgc_pkg::GAIN_RESET : qsum[5:0]) : code[g];
			// R3 R4: clamp, amplifier takes first 12 dB
			wire [5:0] cl = (eff[g] > dgc_pkg::GAIN_MIN_CODE) ? dgc_pkg::GAIN_MIN_CODE : eff[g]; // R3
			wire [5:0] amp_red = (cl > dgc_pkg::AMP_SPAN) ? dgc_pkg::AMP_SPAN : cl; // R4
			wire [5:0] att = cl - amp_red; // R4
			wire [5:0] amp_db = {1'b0, dgc_pkg::AMP_MAX_DB} - amp_red;
			// R16 R21: outputs keep following the code while asleep, code never cleared
			if (g == 0) begin : g_a
				always_ff @(posedge CLK_IN) begin
					GAIN_A_OUT <= RST_N_IN ? cl : dgc_pkg::GAIN_MIN_CODE; // R2
					ATTEN_A_OUT <= RST_N_IN ? att[4:0] : dgc_pkg::ATTEN_MAX;
					AMP_A_OUT <= RST_N_IN ? amp_db[4:0] : 5'(dgc_pkg::AMP_MAX_DB - 5'(dgc_pkg::AMP_SPAN));
				end
			end else begin : g_b
				always_ff @(posedge CLK_IN) begin
					GAIN_B_OUT <= RST_N_IN ? cl : dgc_pkg::GAIN_MIN_CODE; // R2
					ATTEN_B_OUT <= RST_N_IN ? att[4:0] : dgc_pkg::ATTEN_MAX;
					AMP_B_OUT <= RST_N_IN ? amp_db[4:0] : 5'(dgc_pkg::AMP_MAX_DB - 5'(dgc_pkg::AMP_SPAN));
				end
			end
		end
	endgenerate
	always_ff @(posedge CLK_IN) begin
		ENABLE_OUT <= RST_N_IN ? {pwr[0], pwr[1]} : 2'b00; // R16
		LOW_POWER_OUT <= RST_N_IN ? pm : 1'b0; // R17
		WORD_A_OUT <= RST_N_IN ? word_a : '0; // R6
		WORD_B_OUT <= RST_N_IN ? word_b : '0; // R6
	end
endmodule : dgc_device

// ### rtl/dgc_host.sv
`timescale 1ns/10ps
module dgc_host (
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	dgc_if.host              link,
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [15:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic [15:0]      RDATA_OUT
);
	// register map: 0 mode/power, 1 chan a pins, 2 chan b pins, 3 serial word, 4 serial go/status, 5 read word
	localparam logic [3:0] R_CTRL = 4'h0, R_PA = 4'h1, R_PB = 4'h2, R_WORD = 4'h3, R_GO = 4'h4, R_RDW = 4'h5;
	logic [15:0] ctrl, pa, pb, word, rdw;
	logic [1:0]  go_sel;
	logic        read_op;
	logic [4:0]  bits;
	logic [2:0]  half;
	dgc_pkg::dgc_host_e st;
	logic        s1, s2;
	wire busy = (st != dgc_pkg::DGC_IDLE);
	wire tick = (half == 3'(dgc_pkg::SCLK_HALF_CYC - 1));
	always_ff @(posedge CLK_IN) begin
		s1 <= RST_N_IN ? link.sdio_line : 1'b0;
		s2 <= RST_N_IN ? s1 : 1'b0;
	end
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			ctrl <= '0; pa <= '0; pb <= '0; word <= '0; rdw <= '0;
			st <= dgc_pkg::DGC_IDLE; bits <= '0; half <= '0; go_sel <= '0; read_op <= 1'b0;
		end else begin
			if (WR_IN && ADDR_IN == R_CTRL) ctrl <= WDATA_IN;
			if (WR_IN && ADDR_IN == R_PA) pa <= WDATA_IN;
			if (WR_IN && ADDR_IN == R_PB) pb <= WDATA_IN;
			if (WR_IN && ADDR_IN == R_WORD && !busy) word <= WDATA_IN;
			half <= (busy && !tick) ? half + 3'h1 : 3'h0;
			unique case (st)
				dgc_pkg::DGC_IDLE: if (WR_IN && ADDR_IN == R_GO && WDATA_IN[1:0] != 2'b00) begin
					go_sel <= WDATA_IN[1:0];
					read_op <= WDATA_IN[2];
					bits <= 5'h10;
					st <= dgc_pkg::DGC_LOW;
				end
				dgc_pkg::DGC_LOW: if (tick) st <= (bits == 5'h00) ? dgc_pkg::DGC_DONE : dgc_pkg::DGC_HIGH;
				dgc_pkg::DGC_HIGH: if (tick) begin
					// R19: sample device data on falling edge
					if (read_op) rdw <= {rdw[14:0], s2};
					else word <= {word[14:0], 1'b0}; // R7
					bits <= bits - 5'h01;
					st <= dgc_pkg::DGC_LOW;
				end
				dgc_pkg::DGC_DONE: if (tick) st <= dgc_pkg::DGC_IDLE;
			endcase
		end
	end
	wire sclk = (st == dgc_pkg::DGC_HIGH);
	wire [1:0] sel_n = (st == dgc_pkg::DGC_IDLE) ? 2'b11 : ~go_sel; // R9
	assign link.iface_sel = ctrl[1:0]; // R1
	assign link.power_mode_select = ctrl[2];
	assign link.chan_a_power_up = ctrl[3];
	assign link.chan_b_power_up = ctrl[4];
	assign link.chan_a_hold = ctrl[5];
	assign link.chan_b_hold = ctrl[6];
	// in serial mode the shared pins carry select, clock and quick attenuation
	wire serial = (ctrl[1:0] == dgc_pkg::IFACE_SERIAL);
	assign link.chan_a_gain_inputs = serial ? {pa[5:4], sel_n[0], pa[2:0]} : pa[5:0];
	assign link.chan_b_gain_inputs = serial ? {1'b1, sclk, sel_n[1], pb[2:0]} : pb[5:0];
	assign link.sdio_host_out = word[15]; // R7
	assign link.sdio_host_oe = serial && busy && !read_op;
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) RDATA_OUT <= '0;
		else if (RD_IN) begin
			unique case (ADDR_IN)
				R_CTRL: RDATA_OUT <= ctrl;
				R_PA: RDATA_OUT <= pa;
				R_PB: RDATA_OUT <= pb;
				R_WORD: RDATA_OUT <= word;
				R_GO: RDATA_OUT <= {15'h0000, busy};
				R_RDW: RDATA_OUT <= rdw;
				default: RDATA_OUT <= '0;
			endcase
		end else RDATA_OUT <= '0;
	end
endmodule : dgc_host

// ### testbench/dgc_sva.sv
`timescale 1ns/10ps
module dgc_sva (
	input wire logic       CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic [1:0] iface_sel,
	input wire logic [5:0] chan_a_gain_inputs,
	input wire logic [5:0] chan_b_gain_inputs,
	input wire logic       sdio_dev_out,
	input wire logic       sdio_dev_oe,
	input wire logic       sdio_host_oe
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire sel_a_n = chan_a_gain_inputs[3];
	wire sel_b_n = chan_b_gain_inputs[3];
	wire sclk    = chan_b_gain_inputs[4];
	wire serial  = iface_sel == dgc_pkg::IFACE_SERIAL;
	a_no_bus_fight: assert property (!(sdio_dev_oe && sdio_host_oe))
		else $error("both ends drive the data line");
	a_read_when_selected: assert property ($rose(sdio_dev_oe) |-> serial && !(sel_a_n && sel_b_n))
		else $error("read drive without select");
	a_read_one_chan: assert property ($rose(sdio_dev_oe) |-> sel_a_n != sel_b_n)
		else $error("read drive with both selects");
	a_release_when_idle: assert property ((sel_a_n && sel_b_n) [*6] |-> !sdio_dev_oe)
		else $error("data line held after deselect");
	a_parallel_no_drive: assert property ((iface_sel == dgc_pkg::IFACE_PARALLEL) [*4] |-> !sdio_dev_oe)
		else $error("data line driven in parallel mode");
	a_count_no_drive: assert property (iface_sel[1] [*4] |-> !sdio_dev_oe)
		else $error("data line driven in count mode");
	a_data_on_rise: assert property (sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_out) |-> sclk)
		else $error("read data changed while clock low");
	a_clock_half: assert property (serial && $rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("serial clock high phase not four cycles");
	c_read: cover property ($rose(sdio_dev_oe));
	c_both_sel: cover property (serial && !sel_a_n && !sel_b_n);
	c_count: cover property (iface_sel[1] && $rose(chan_a_gain_inputs[1]));
endmodule : dgc_sva

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        look = 1'b0;
	logic [3:0]  pidx = 4'h0;
	logic [15:0] rdata, word_a, word_b, obs, ev;
	logic [15:0] x = 16'h9A90;
	logic [5:0]  gain_a, gain_b, c;
	logic [4:0]  atten_a, atten_b, amp_a, amp_b;
	logic [1:0]  enable;
	logic        low_power;
	logic [15:0] q[$];
	int          err_total = 0;
	int          check_count = 0;
	int          cnt;
	string       nm [0:10] = '{"rdata", "gain_a", "gain_b", "atten_a", "amp_a", "enable", "low_power", "word_a",
		"word_b", "atten_b", "amp_b"};
	logic [5:0]  pc [0:5] = '{6'h00, 6'h0C, 6'h0D, 6'h23, 6'h24, 6'h3F};
	int          st [0:5] = '{3, 2, 1, 0, 3, 3};
	logic        dr [0:5] = '{0, 0, 0, 0, 1, 0};
	int          nn [0:5] = '{4, 1, 1, 1, 1, 5};
	always #12.5 clk = ~clk;
	dgc_if link_if ();
	dgc_device dgc_device_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .link(link_if), .GAIN_A_OUT(gain_a),
		.GAIN_B_OUT(gain_b), .ATTEN_A_OUT(atten_a), .ATTEN_B_OUT(atten_b), .AMP_A_OUT(amp_a), .AMP_B_OUT(amp_b),
		.ENABLE_OUT(enable), .LOW_POWER_OUT(low_power), .WORD_A_OUT(word_a), .WORD_B_OUT(word_b));
	dgc_host dgc_host_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .link(link_if), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata));
	dgc_sva dgc_sva_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .iface_sel(link_if.iface_sel),
		.chan_a_gain_inputs(link_if.chan_a_gain_inputs), .chan_b_gain_inputs(link_if.chan_b_gain_inputs),
		.sdio_dev_out(link_if.sdio_dev_out), .sdio_dev_oe(link_if.sdio_dev_oe), .sdio_host_oe(link_if.sdio_host_oe));
	always_comb case (pidx)
		4'h1: obs = {10'h000, gain_a};
		4'h2: obs = {10'h000, gain_b};
		4'h3: obs = {11'h000, atten_a};
		4'h4: obs = {11'h000, amp_a};
		4'h5: obs = {14'h0000, enable};
		4'h6: obs = {15'h0000, low_power};
		4'h7: obs = word_a;
		4'h8: obs = word_b;
		4'h9: obs = {11'h000, atten_b};
		4'hA: obs = {11'h000, amp_b};
		default: obs = rdata;
	endcase
	always @(posedge clk) if (look) begin
		ev = q.pop_front();
		check_count++;
		if (obs !== ev) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm[pidx], ev, obs);
		end
	end
	function automatic logic [15:0] nxt(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction : nxt
	// effective code clamps at the -9 dB floor
	function automatic logic [15:0] eff(input int v);
		return v > 35 ? 16'h0023 : 16'(v);
	endfunction : eff
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// settle margin covers the two-flop input synchronisers
	task automatic chk(input logic [3:0] i, input logic [15:0] v);
		q.push_back(v);
		repeat (8) @(posedge clk);
		pidx <= i;
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask : chk
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] v);
		q.push_back(v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		pidx <= 4'h0;
		@(posedge clk);
		rd <= 1'b0;
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask : rd_reg
	task automatic wait_idle();
		for (int n = 0; n < 200; n++) begin
			@(posedge clk);
			addr <= 4'h4;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			if (rdata[0] === 1'b0) return;
		end
		err_total++;
		summarize();
	endtask : wait_idle
	task automatic pulse(input logic d_rise, input logic d_fall);
		wr_reg(4'h1, {15'h0000, d_rise});
		wr_reg(4'h1, {14'h0000, 1'b1, d_rise});
		wr_reg(4'h1, {14'h0000, 1'b1, d_fall});
		wr_reg(4'h1, {15'h0000, d_fall});
	endtask : pulse
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		chk(4'h7, 16'h003F);
		wr_reg(4'h0, 16'h001C);
		chk(4'h5, 16'h0003);
		chk(4'h6, 16'h0001);
		for (int i = 0; i < 9; i++) begin
			x = nxt(x);
			c = i < 6 ? pc[i] : x[5:0];
			wr_reg(4'h1, {10'h000, c});
			chk(4'h1, eff(c));
			chk(4'h4, c < 12 ? 16'(26 - c) : 16'h000E);
			chk(4'h3, eff(c) > 12 ? eff(c) - 16'h000C : 16'h0000);
		end
		wr_reg(4'h9, 16'hFFFF);
		chk(4'h1, eff(c));
		wr_reg(4'h0, 16'h0034);
		wr_reg(4'h1, 16'h0005);
		chk(4'h5, 16'h0002);
		chk(4'h1, eff(c));
		wr_reg(4'h0, 16'h0019);
		wr_reg(4'h1, 16'h0008);
		wr_reg(4'h2, 16'h0008);
		wr_reg(4'h3, 16'h0045);
		wr_reg(4'h4, 16'h0003);
		wait_idle();
		chk(4'h7, 16'h0045);
		chk(4'h8, 16'h0045);
		chk(4'h2, 16'h0005);
		chk(4'h9, 16'h0000);
		chk(4'hA, 16'h0015);
		chk(4'h6, 16'h0000);
		for (int s = 0; s < 4; s++) begin
			wr_reg(4'h3, {8'h00, 2'(s), 6'h1E});
			wr_reg(4'h4, 16'h0001);
			wait_idle();
			wr_reg(4'h1, 16'h000C);
			chk(4'h1, eff(30 + (2 << s)));
			wr_reg(4'h1, 16'h0008);
			chk(4'h1, 16'h001E);
		end
		wr_reg(4'h3, 16'h0116);
		wr_reg(4'h4, 16'h0001);
		wait_idle();
		wr_reg(4'h4, 16'h0005);
		wait_idle();
		rd_reg(4'h5, 16'h0116);
		wr_reg(4'h0, 16'h001A);
		pulse(1'b0, 1'b1);
		cnt = 63;
		chk(4'h1, eff(cnt));
		for (int k = 0; k < 6; k++) begin
			wr_reg(4'h2, {12'h000, 2'(st[k]), 2'b00});
			repeat (nn[k]) begin
				pulse(dr[k], dr[k]);
				cnt = dr[k] ? cnt + (1 << st[k]) : cnt - (1 << st[k]);
				cnt = cnt < 0 ? 0 : cnt > 63 ? 63 : cnt;
			end
			chk(4'h1, eff(cnt));
		end
		wr_reg(4'h0, 16'h001B);
		pulse(1'b1, 1'b1);
		chk(4'h1, 16'h0008);
		summarize();
	end
endmodule : tb
